// File: common/hcs_pkg.sv
// package: operating-control register constants and functional states
package hcs_pkg;
    localparam logic [7:0] HCS_CMD_RD = 8'h01;
    localparam logic [7:0] HCS_CMD_WR = 8'h81;
    localparam int HCS_RWE_BIT = 10;
    localparam int HCS_RWC_BIT = 9;
    localparam int HCS_FS_LSB = 6;
    localparam logic [1:0] HCS_FS_BUS_RESET = 2'h0;
    localparam logic [1:0] HCS_FS_RESUMING = 2'h1;
    localparam logic [1:0] HCS_FS_OPERATIONAL = 2'h2;
    localparam logic [1:0] HCS_FS_SUSPENDED = 2'h3;
    localparam logic [31:0] HCS_CTRL_RESET = 32'h0000_0000;
    localparam int HCS_CLK_MHZ = 250;
    localparam int HCS_SOF_DELAY_US = 1000;
    localparam int HCS_SOF_DELAY_CYC = HCS_SOF_DELAY_US * HCS_CLK_MHZ;
    localparam int HCS_CNT_W = 18;
    localparam int HCS_BUSRST_CYC = 16;
endpackage

// File: core/hcs_ctrl.sv
// operating-control register and functional-state logic
`timescale 1ns/10ps
// Functional notes
// - remote wake is signalled when wake enable and the resume-detected flag are both set.
// - wake enable has no effect on the hardware interrupt request.
// - wake connected clears on hardware reset and survives a software reset.
// - the state field at bits 7..6 encodes reset, resuming, operational, suspended; hardware changes it only from suspended.
// - frame-start generation begins 1 ms after entering operational from another state.
// - while suspended, resume signalling on any downstream port moves the state to resuming.
// - software or hardware reset puts the state into bus reset.
// - hardware reset also resets the root hub and drives reset signalling downstream.
// - the register is read with command 01 and written with command 81.
module hcs_ctrl
    import hcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    output logic [31:0] cmd_rdata,
    output logic cmd_rvalid,
    input wire logic soft_reset,
    input wire logic resume_detected_flag,
    input wire logic [1:0] port_resume_pin,
    input wire logic irq_request,
    output logic irq_out,
    output logic remote_wake_out,
    output logic sof_enable,
    output logic frame_start_flag,
    output logic root_hub_reset,
    output logic port_reset_drive,
    output logic [1:0] functional_state
);
    import hcs_pkg::*;

    logic remote_wake_enable;
    logic remote_wake_connected;
    logic [HCS_CNT_W-1:0] sof_cnt;
    logic [4:0] busrst_cnt;
    logic hw_rst_pending;
    logic [1:0] port_resume_s;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            hcs_sync u_sync (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .clk_en(clk_en),
                .din(port_resume_pin[gi]),
                .dout(port_resume_s[gi])
            );
        end
    endgenerate

    wire rd_hit = cmd_valid && (cmd_code == HCS_CMD_RD);
    wire wr_hit = cmd_valid && (cmd_code == HCS_CMD_WR);
    wire resume_seen = |port_resume_s;
    wire hw_resume = (functional_state == HCS_FS_SUSPENDED) && resume_seen && !wr_hit;
    wire [1:0] wr_fs = cmd_wdata[HCS_FS_LSB+1:HCS_FS_LSB];
    wire sof_done = (sof_cnt == HCS_CNT_W'(HCS_SOF_DELAY_CYC - 1));
    wire [31:0] read_word = {21'h0, remote_wake_enable, remote_wake_connected, 1'b0, functional_state, 6'h0};
    wire [1:0] next_state = soft_reset ? HCS_FS_BUS_RESET :
                            wr_hit ? wr_fs :
                            hw_resume ? HCS_FS_RESUMING : functional_state;

    // wake bits, software reset keeps connected
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remote_wake_enable <= 1'b0;
            remote_wake_connected <= 1'b0;
        end
        else if (clk_en && wr_hit)
        begin
            remote_wake_enable <= cmd_wdata[HCS_RWE_BIT];
            remote_wake_connected <= cmd_wdata[HCS_RWC_BIT];
        end
        else if (clk_en && soft_reset)
            remote_wake_enable <= 1'b0;
    end

    // state register, reset to bus reset
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            functional_state <= HCS_FS_BUS_RESET;
        else if (clk_en)
            functional_state <= next_state;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sof_cnt <= '0;
            sof_enable <= 1'b0;
            frame_start_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (next_state != HCS_FS_OPERATIONAL)
            begin
                sof_cnt <= '0;
                sof_enable <= 1'b0;
            end
            else if (functional_state != HCS_FS_OPERATIONAL)
                sof_cnt <= '0;
            else if (!sof_enable && sof_done)
                sof_enable <= 1'b1;
            else if (!sof_enable)
                sof_cnt <= sof_cnt + 1'b1;
            frame_start_flag <= sof_enable;
        end
    end

    // root hub reset and downstream reset after hardware reset
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hw_rst_pending <= 1'b1;
            busrst_cnt <= '0;
            root_hub_reset <= 1'b1;
            port_reset_drive <= 1'b0;
        end
        else if (clk_en && hw_rst_pending)
        begin
            root_hub_reset <= 1'b0;
            port_reset_drive <= 1'b1;
            busrst_cnt <= busrst_cnt + 1'b1;
            // downstream reset stands for the full count of enabled cycles
            if (busrst_cnt == 5'(HCS_BUSRST_CYC))
            begin
                hw_rst_pending <= 1'b0;
                port_reset_drive <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remote_wake_out <= 1'b0;
            irq_out <= 1'b0;
            cmd_rdata <= HCS_CTRL_RESET;
            cmd_rvalid <= 1'b0;
        end
        else if (clk_en)
        begin
            remote_wake_out <= remote_wake_enable && resume_detected_flag;
            irq_out <= irq_request;
            cmd_rvalid <= rd_hit;
            if (rd_hit)
                cmd_rdata <= read_word;
        end
    end

    wake_cause_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en ##1 1'b1 |-> remote_wake_out == $past(remote_wake_enable && resume_detected_flag))
        else $error("remote wake mismatch");
    irq_indep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en |=> irq_out == $past(irq_request))
        else $error("interrupt tied to wake enable");
    rwc_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && soft_reset && !wr_hit) |=> $stable(remote_wake_connected))
        else $error("connected bit lost on soft reset");
    hw_change_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && !wr_hit && !soft_reset && functional_state != HCS_FS_SUSPENDED) |=> $stable(functional_state))
        else $error("state changed outside suspended");
    resume_go_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && hw_resume && !soft_reset) |=> functional_state == HCS_FS_RESUMING)
        else $error("resume not entered");
    soft_rst_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && soft_reset) |=> functional_state == HCS_FS_BUS_RESET)
        else $error("soft reset missed");
    sof_early_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (functional_state != HCS_FS_OPERATIONAL) |-> !sof_enable)
        else $error("frame start outside operational");
    // enabled cycles spent in operational, independent of the frame counter
    logic [HCS_CNT_W-1:0] oper_age;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            oper_age <= '0;
        else if (clk_en && functional_state != HCS_FS_OPERATIONAL)
            oper_age <= '0;
        else if (clk_en && oper_age != '1)
            oper_age <= oper_age + 1'b1;
    end
    sof_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && functional_state == HCS_FS_OPERATIONAL && next_state == HCS_FS_OPERATIONAL
            && oper_age == HCS_CNT_W'(HCS_SOF_DELAY_CYC - 1)) |=> sof_enable)
        else $error("frame start late");
    sof_rise_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(sof_enable) |-> $past(oper_age) == HCS_CNT_W'(HCS_SOF_DELAY_CYC - 1))
        else $error("frame start early");
    state_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !clk_en |=> $stable(functional_state) && $stable(sof_enable) && $stable(irq_out))
        else $error("state moved while frozen");
    read_ans_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && rd_hit) |=> cmd_rvalid && cmd_rdata == $past(read_word))
        else $error("read answer wrong");
    rsv_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_rvalid |-> (cmd_rdata[31:11] == 21'h0 && cmd_rdata[8] == 1'b0 && cmd_rdata[5:0] == 6'h0))
        else $error("reserved bits nonzero");
    sequence hw_rel_s;
        hw_rst_pending && clk_en;
    endsequence
    bus_rst_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        hw_rel_s |=> port_reset_drive || !hw_rst_pending)
        else $error("no downstream reset");
endmodule

// File: core/hcs_sync.sv
// two-flop synchroniser for a pin level
`timescale 1ns/10ps
module hcs_sync (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic din,
    output logic dout
);
    logic stage1;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end
        else if (clk_en)
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// File: tb/hcs_host_model.sv
// host driver model issuing register commands
`timescale 1ns/10ps
module hcs_host_model
    import hcs_pkg::*;
(
    input wire logic core_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [31:0] cmd_wdata,
    input wire logic [31:0] cmd_rdata,
    input wire logic cmd_rvalid
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 32'h0000_0000;
    end
    task automatic issue(input logic [7:0] code, input logic [31:0] data);
    begin
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_code = ~code;
        cmd_wdata = ~data;
    end
    endtask
    task automatic wr(input logic [31:0] data);
        issue(HCS_CMD_WR, data);
    endtask
    task automatic rd(output logic [31:0] data, output logic ok);
        ok = 1'b0;
        data = 32'h0000_0000;
        issue(HCS_CMD_RD, 32'h0000_0000);
        for (int n = 0; n < 4 && ok !== 1'b1; n++)
        begin
            if (cmd_rvalid === 1'b1)
            begin
                ok = 1'b1;
                data = cmd_rdata;
            end
            else
                @(negedge core_clk);
        end
    endtask
endmodule

// File: tb/tb_hcs_ctrl.sv
// self-checking bench for the operating-control block
`timescale 1ns/10ps
module tb_hcs_ctrl;
    import hcs_pkg::*;
    logic core_clk, rst_b, clk_en, cmd_valid, cmd_rvalid, soft_reset, resume_detected_flag, irq_request;
    logic irq_out, remote_wake_out, sof_enable, frame_start_flag, root_hub_reset, port_reset_drive;
    logic [7:0] cmd_code;
    logic [31:0] cmd_wdata, cmd_rdata;
    logic [1:0] port_resume_pin, functional_state;
    int n_errors = 0;
    int num_checks = 0;
    hcs_ctrl hcs_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .soft_reset(soft_reset), .resume_detected_flag(resume_detected_flag),
        .port_resume_pin(port_resume_pin), .irq_request(irq_request), .irq_out(irq_out),
        .remote_wake_out(remote_wake_out), .sof_enable(sof_enable), .frame_start_flag(frame_start_flag),
        .root_hub_reset(root_hub_reset), .port_reset_drive(port_reset_drive),
        .functional_state(functional_state));
    hcs_host_model hcs_host_model_i (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic give_up();
        n_errors++;
        $display("ERROR %0t wait limit reached", $time);
        tally_and_finish();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        hcs_host_model_i.rd(d, ok);
        if (ok !== 1'b1)
            give_up();
        else
            chk(d, exp);
    endtask
    task automatic hw_reset();
        int n;
        n = 0;
        @(negedge core_clk);
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({root_hub_reset, port_reset_drive, functional_state}, 4'b1000);
        rst_b = 1'b1;
        @(negedge core_clk);
        chk({root_hub_reset, port_reset_drive}, 2'b01);
        while (port_reset_drive === 1'b1 && n < 40)
        begin
            n++;
            @(negedge core_clk);
        end
        if (n >= 40)
            give_up();
        else
        begin
            chk(n, HCS_BUSRST_CYC);
            rdchk(32'h0000_0000);
        end
    endtask
    task automatic t_write_oper();
        hcs_host_model_i.wr(32'hFFFF_FFBF);
        rdchk(32'h0000_0680);
        chk(functional_state, HCS_FS_OPERATIONAL);
        repeat (1000) @(negedge core_clk);
        chk({sof_enable, frame_start_flag}, 2'b00);
    endtask
    task automatic t_wake();
        irq_request = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({remote_wake_out, irq_out}, 2'b01);
        resume_detected_flag = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({remote_wake_out, irq_out}, 2'b11);
        hcs_host_model_i.wr(32'h0000_0280);
        repeat (3) @(negedge core_clk);
        chk({remote_wake_out, irq_out}, 2'b01);
        irq_request = 1'b0;
        resume_detected_flag = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({remote_wake_out, irq_out}, 2'b00);
    endtask
    task automatic t_freeze();
        hcs_host_model_i.wr(32'h0000_02C0);
        @(negedge core_clk);
        clk_en = 1'b0;
        irq_request = 1'b1;
        port_resume_pin = 2'b01;
        hcs_host_model_i.wr(32'h0000_0080);
        repeat (4) @(negedge core_clk);
        chk({irq_out, functional_state}, 3'b011);
        clk_en = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({irq_out, functional_state}, 3'b101);
        irq_request = 1'b0;
        port_resume_pin = 2'b00;
    endtask
    task automatic t_resume();
        port_resume_pin = 2'b10;
        repeat (6) @(negedge core_clk);
        chk(functional_state, HCS_FS_OPERATIONAL);
        hcs_host_model_i.wr(32'h0000_02C0);
        repeat (8) @(negedge core_clk);
        chk(functional_state, HCS_FS_RESUMING);
        port_resume_pin = 2'b00;
    endtask
    task automatic t_soft();
        hcs_host_model_i.wr(32'h0000_0680);
        @(negedge core_clk);
        soft_reset = 1'b1;
        @(negedge core_clk);
        soft_reset = 1'b0;
        repeat (2) @(negedge core_clk);
        rdchk(32'h0000_0200);
    endtask
    initial
    begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        soft_reset = 1'b0;
        resume_detected_flag = 1'b0;
        irq_request = 1'b0;
        port_resume_pin = 2'b00;
        hw_reset();
        t_write_oper();
        t_wake();
        t_resume();
        t_soft();
        t_freeze();
        hw_reset();
        tally_and_finish();
    end
endmodule
